// >>> shared/lcfc_pkg.sv
// constants and register map of the limit check failure counter
package lcfc_pkg;
  localparam int LCFC_ADDR_W = 8;
  localparam int LCFC_DATA_W = 32;
  localparam int LCFC_TALLY_W = 16;
  // register byte offsets
  localparam logic [7:0] LCFC_OFS_CTRL = 8'h00;
  localparam logic [7:0] LCFC_OFS_LOWER = 8'h04;
  localparam logic [7:0] LCFC_OFS_UPPER = 8'h08;
  localparam logic [7:0] LCFC_OFS_BCMD = 8'h0C;
  localparam logic [7:0] LCFC_OFS_BMIN = 8'h10;
  localparam logic [7:0] LCFC_OFS_BMAX = 8'h14;
  localparam logic [7:0] LCFC_OFS_CLEAR = 8'h18;
  localparam logic [7:0] LCFC_OFS_TALLY = 8'h1C;
  localparam logic [7:0] LCFC_OFS_IRQ_STAT = 8'h20;
  localparam logic [7:0] LCFC_OFS_IRQ_CLR = 8'h24;
  localparam logic [7:0] LCFC_OFS_IRQ_EN = 8'h28;
  localparam logic [7:0] LCFC_OFS_ERR = 8'h2C;
  // control fields
  localparam int LCFC_CTRL_EN_BIT = 0;
  localparam int LCFC_CTRL_POL_LSB = 1;
  localparam int LCFC_CTRL_LIN_BIT = 3;
  localparam logic [1:0] LCFC_POL_OFF = 2'h0;
  localparam logic [1:0] LCFC_POL_EVERY = 2'h1;
  localparam logic [1:0] LCFC_POL_ONCE = 2'h2;
  // bound command fields
  localparam int LCFC_BCMD_SEL_BIT = 0;
  localparam int LCFC_BCMD_CODE_LSB = 1;
  localparam logic [1:0] LCFC_BCMD_DEF = 2'h1;
  localparam logic [1:0] LCFC_BCMD_MIN = 2'h2;
  localparam logic [1:0] LCFC_BCMD_MAX = 2'h3;
  localparam int LCFC_CLEAR_BIT = 0;
  localparam int LCFC_FAIL_BIT = 16;
  // interrupt events
  localparam int LCFC_IRQ_W = 3;
  localparam int LCFC_EV_FAIL = 0;
  localparam int LCFC_EV_CONFLICT = 1;
  localparam int LCFC_EV_WRAP = 2;
  // bounds in hundredths of dBm
  localparam logic signed [31:0] LCFC_BOUND_MIN = -32'sd15000;
  localparam logic signed [31:0] LCFC_BOUND_MAX = 32'sd23000;
  localparam logic signed [31:0] LCFC_LOWER_DEF = -32'sd9000;
  localparam logic signed [31:0] LCFC_UPPER_DEF = 32'sd9000;
  localparam logic signed [15:0] LCFC_ERR_CONFLICT = -16'sd221;
endpackage

// >>> core/lcfc_compare.sv
// bound comparison of one measurement result
`timescale 1ns/1ps
`default_nettype none
module lcfc_compare
  import lcfc_pkg::*;
#(
  parameter int DATA_W = LCFC_DATA_W
)(
  input wire logic [DATA_W-1:0] result_i,
  input wire logic [DATA_W-1:0] lower_i,
  input wire logic [DATA_W-1:0] upper_i,
  input wire logic linear_i,
  output logic below_o,
  output logic above_o
);
  // log scale is signed hundredths of dBm, linear scale is unsigned power
  always_comb
  begin
    if (linear_i)
    begin
      below_o = result_i < lower_i;
      above_o = result_i > upper_i;
    end
    else
    begin
      below_o = $signed(result_i) < $signed(lower_i);
      above_o = $signed(result_i) > $signed(upper_i);
    end
  end
endmodule
`default_nettype wire

// >>> core/lcfc_tally.sv
// wrapping failure tally with clear priority
`timescale 1ns/1ps
`default_nettype none
module lcfc_tally
  import lcfc_pkg::*;
#(
  parameter int TALLY_W = LCFC_TALLY_W
)(
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic clear_i,
  input wire logic inc_i,
  output logic [TALLY_W-1:0] count_o,
  output logic nonzero_o,
  output logic wrap_o
);
  logic [TALLY_W-1:0] count_ff;
  logic [TALLY_W-1:0] nxt_count;
  logic nonzero_ff;
  logic wrap_ff;

  always_comb
  begin
    if (clear_i)
      nxt_count = '0;
    else if (inc_i)
      nxt_count = count_ff + 1'b1;
    else
      nxt_count = count_ff;
  end

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      count_ff <= '0;
      nonzero_ff <= 1'b0;
      wrap_ff <= 1'b0;
    end
    else
    begin
      count_ff <= nxt_count;
      nonzero_ff <= |nxt_count;
      wrap_ff <= !clear_i && inc_i && (&count_ff);
    end
  end

  assign count_o = count_ff;
  assign nonzero_o = nonzero_ff;
  assign wrap_o = wrap_ff;
endmodule
`default_nettype wire

// >>> core/lcfc_top.sv
// limit check failure counter: registers, bounds, auto clear and interrupt
// Operation
// - enabled check adds exactly one to tally per out-of-bounds result in a cycle with no tally clear
// - result equal to either bound passes
// - tally zeroed by reset, immediate clear, and selecting every-measurement clearing
// - every-measurement policy zeroes tally at each measurement start
// - once policy zeroes tally only at first start after selection
// - tally counts to 65535 then wraps to zero
// - result strictly below lower bound fails
// - result strictly above upper bound fails
// - log-scale bounds limited to -150..+230 dBm, min/max shortcuts and queries
// - lower bound loads -90.00 dBm on reset and default shortcut
// - upper bound loads +90.00 dBm on reset and default shortcut
// - bounds compared in the selected log or linear unit
// - enable cleared on reset; disabled check never advances tally
// - enable reads back as 1 active, 0 inactive
// - enabling refused with error -221 under fast rate or speed 400
// - tally query returns failures since last clear
// - failure flag is 1 exactly when tally is non-zero
// - auto-clear policy resets to every-measurement
`timescale 1ns/1ps
`default_nettype none
module lcfc_top
  import lcfc_pkg::*;
#(
  parameter int ADDR_W = LCFC_ADDR_W,
  parameter int DATA_W = LCFC_DATA_W,
  parameter int TALLY_W = LCFC_TALLY_W
)(
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [DATA_W-1:0] rdata_o,
  input wire logic meas_start_i,
  input wire logic result_valid_i,
  input wire logic [DATA_W-1:0] result_i,
  input wire logic measurement_rate_fast_i,
  input wire logic speed_400_i,
  output logic fail_flag_o,
  output logic irq_o
);
  logic rst_meta_ff;
  logic rst_n_ff;
  logic enable_ff;
  logic [1:0] policy_ff;
  logic linear_ff;
  logic once_pend_ff;
  logic [DATA_W-1:0] lower_ff;
  logic [DATA_W-1:0] upper_ff;
  logic [LCFC_IRQ_W-1:0] irq_stat_ff;
  logic [LCFC_IRQ_W-1:0] irq_en_ff;
  logic irq_ff;
  logic [15:0] err_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic [TALLY_W-1:0] tally;
  logic tally_nonzero;
  logic tally_wrap;
  logic below;
  logic above;
  logic fail_ev;
  logic conflict_ev;
  logic tally_clear;
  logic imm_clear;
  logic auto_clear;
  logic ctrl_wr;
  logic want_enable;
  logic conflict;
  logic [1:0] wr_policy;
  logic [LCFC_IRQ_W-1:0] events;
  logic [1:0] bcmd_code;
  logic signed [DATA_W-1:0] bcmd_val;

  // reset released through two flops
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      rst_meta_ff <= 1'b0;
      rst_n_ff <= 1'b0;
    end
    else
    begin
      rst_meta_ff <= 1'b1;
      rst_n_ff <= rst_meta_ff;
    end
  end

  // clamp a written bound in log scale; linear values are taken as written
  function automatic logic [DATA_W-1:0] clamp_bound(input logic [DATA_W-1:0] v, input logic lin);
    logic [DATA_W-1:0] r;
    r = v;
    if (!lin && ($signed(v) < LCFC_BOUND_MIN))
      r = LCFC_BOUND_MIN;
    else if (!lin && ($signed(v) > LCFC_BOUND_MAX))
      r = LCFC_BOUND_MAX;
    return r;
  endfunction

  assign ctrl_wr = wr_i && (addr_i == LCFC_OFS_CTRL);
  assign want_enable = wdata_i[LCFC_CTRL_EN_BIT];
  assign wr_policy = wdata_i[LCFC_CTRL_POL_LSB +: 2];
  assign conflict = measurement_rate_fast_i || speed_400_i;
  assign conflict_ev = ctrl_wr && want_enable && conflict;
  assign imm_clear = wr_i && (addr_i == LCFC_OFS_CLEAR) && wdata_i[LCFC_CLEAR_BIT];
  assign bcmd_code = wdata_i[LCFC_BCMD_CODE_LSB +: 2];

  // auto clear at a measurement start
  always_comb
  begin
    auto_clear = 1'b0;
    if (meas_start_i && (policy_ff == LCFC_POL_EVERY))
      auto_clear = 1'b1;
    else if (meas_start_i && (policy_ff == LCFC_POL_ONCE) && once_pend_ff)
      auto_clear = 1'b1;
  end

  // selecting every-measurement clearing zeroes the tally right away
  assign tally_clear = imm_clear || auto_clear
    || (ctrl_wr && (wr_policy == LCFC_POL_EVERY));
  assign fail_ev = enable_ff && result_valid_i && (below || above);

  always_comb
  begin
    unique case (bcmd_code)
      LCFC_BCMD_MIN: bcmd_val = LCFC_BOUND_MIN;
      LCFC_BCMD_MAX: bcmd_val = LCFC_BOUND_MAX;
      default: bcmd_val = wdata_i[LCFC_BCMD_SEL_BIT] ? LCFC_UPPER_DEF : LCFC_LOWER_DEF;
    endcase
  end

  lcfc_compare #(
    .DATA_W(DATA_W)
  ) u_compare (
    .result_i(result_i),
    .lower_i(lower_ff),
    .upper_i(upper_ff),
    .linear_i(linear_ff),
    .below_o(below),
    .above_o(above)
  );

  lcfc_tally #(
    .TALLY_W(TALLY_W)
  ) u_tally (
    .clock_i(clock_i),
    .rst_n_i(rst_n_ff),
    .clear_i(tally_clear),
    .inc_i(fail_ev),
    .count_o(tally),
    .nonzero_o(tally_nonzero),
    .wrap_o(tally_wrap)
  );

  // control register; an enable under conflicting speed settings is refused
  always_ff @(posedge clock_i or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
    begin
      enable_ff <= 1'b0;
      policy_ff <= LCFC_POL_EVERY;
      linear_ff <= 1'b0;
    end
    else if (ctrl_wr)
    begin
      enable_ff <= want_enable && !conflict;
      policy_ff <= wr_policy;
      linear_ff <= wdata_i[LCFC_CTRL_LIN_BIT];
    end
  end

  // once policy waits for its first start after being selected
  always_ff @(posedge clock_i or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
      once_pend_ff <= 1'b0;
    else if (ctrl_wr)
      once_pend_ff <= (wr_policy == LCFC_POL_ONCE);
    else if (meas_start_i)
      once_pend_ff <= 1'b0;
  end

  // bounds: direct log-scale writes clamp, shortcut writes load fixed values
  always_ff @(posedge clock_i or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
    begin
      lower_ff <= LCFC_LOWER_DEF;
      upper_ff <= LCFC_UPPER_DEF;
    end
    else if (wr_i)
    begin
      if (addr_i == LCFC_OFS_LOWER)
        lower_ff <= clamp_bound(wdata_i, linear_ff);
      else if (addr_i == LCFC_OFS_UPPER)
        upper_ff <= clamp_bound(wdata_i, linear_ff);
      else if ((addr_i == LCFC_OFS_BCMD) && (bcmd_code != 2'h0))
      begin
        if (wdata_i[LCFC_BCMD_SEL_BIT])
          upper_ff <= bcmd_val;
        else
          lower_ff <= bcmd_val;
      end
    end
  end

  // last error code, kept until a refused enable writes it again
  always_ff @(posedge clock_i or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
      err_ff <= '0;
    else if (conflict_ev)
      err_ff <= LCFC_ERR_CONFLICT;
  end

  // sticky events; a same-cycle event wins over the clear
  assign events[LCFC_EV_FAIL] = fail_ev;
  assign events[LCFC_EV_CONFLICT] = conflict_ev;
  assign events[LCFC_EV_WRAP] = tally_wrap;

  always_ff @(posedge clock_i or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
    begin
      irq_stat_ff <= '0;
      irq_en_ff <= '0;
      irq_ff <= 1'b0;
    end
    else
    begin
      if (wr_i && (addr_i == LCFC_OFS_IRQ_CLR))
        irq_stat_ff <= (irq_stat_ff & ~wdata_i[LCFC_IRQ_W-1:0]) | events;
      else
        irq_stat_ff <= irq_stat_ff | events;
      if (wr_i && (addr_i == LCFC_OFS_IRQ_EN))
        irq_en_ff <= wdata_i[LCFC_IRQ_W-1:0];
      irq_ff <= |(irq_stat_ff & irq_en_ff);
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clock_i or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
      rdata_ff <= '0;
    else if (!rd_i)
      rdata_ff <= '0;
    else
    begin
      unique case (addr_i)
        LCFC_OFS_CTRL: rdata_ff <= {{(DATA_W-4){1'b0}}, linear_ff, policy_ff, enable_ff};
        LCFC_OFS_LOWER: rdata_ff <= lower_ff;
        LCFC_OFS_UPPER: rdata_ff <= upper_ff;
        LCFC_OFS_BMIN: rdata_ff <= LCFC_BOUND_MIN;
        LCFC_OFS_BMAX: rdata_ff <= LCFC_BOUND_MAX;
        LCFC_OFS_TALLY: rdata_ff <= {{(DATA_W-TALLY_W-1){1'b0}}, tally_nonzero, tally};
        LCFC_OFS_IRQ_STAT: rdata_ff <= {{(DATA_W-LCFC_IRQ_W){1'b0}}, irq_stat_ff};
        LCFC_OFS_IRQ_EN: rdata_ff <= {{(DATA_W-LCFC_IRQ_W){1'b0}}, irq_en_ff};
        LCFC_OFS_ERR: rdata_ff <= {{(DATA_W-16){err_ff[15]}}, err_ff};
        default: rdata_ff <= '0;
      endcase
    end
  end

  assign rdata_o = rdata_ff;
  assign fail_flag_o = tally_nonzero;
  assign irq_o = irq_ff;

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_ff);

  a_fail_increments_one: assert property (fail_ev && !tally_clear |=> tally == $past(tally) + 1'b1)
    else $error("tally did not advance by one on a failure");
  a_equal_bound_pass: assert property (result_valid_i && !linear_ff
    && (result_i == lower_ff || result_i == upper_ff) && !tally_clear |=> tally == $past(tally))
    else $error("result equal to a bound advanced the tally");
  a_clear_wins_inc: assert property (tally_clear |=> tally == '0)
    else $error("tally not zero after a clear");
  a_every_start_clear: assert property (meas_start_i && policy_ff == LCFC_POL_EVERY |=> tally == '0)
    else $error("every-measurement start did not zero tally");
  a_once_no_reclear: assert property (meas_start_i && policy_ff == LCFC_POL_ONCE && !once_pend_ff
    && !imm_clear && !ctrl_wr && !fail_ev |=> tally == $past(tally))
    else $error("once policy cleared tally again");
  a_tally_wraps: assert property (fail_ev && !tally_clear && (&tally) |=> tally == '0)
    else $error("tally did not wrap to zero");
  a_below_lower_fails: assert property (enable_ff && result_valid_i && !linear_ff
    && $signed(result_i) < $signed(lower_ff) && !tally_clear |=> tally != $past(tally))
    else $error("result below lower bound not counted");
  a_above_upper_fails: assert property (enable_ff && result_valid_i && !linear_ff
    && $signed(result_i) > $signed(upper_ff) && !tally_clear |=> tally != $past(tally))
    else $error("result above upper bound not counted");
  // only a log-scale write is range checked; a bound kept from linear scale is not converted
  a_bound_range: assert property (wr_i && !linear_ff && addr_i == LCFC_OFS_LOWER
    |=> $signed(lower_ff) >= LCFC_BOUND_MIN && $signed(lower_ff) <= LCFC_BOUND_MAX)
    else $error("lower bound outside allowed range");
  a_upper_range: assert property (wr_i && !linear_ff && addr_i == LCFC_OFS_UPPER
    |=> $signed(upper_ff) >= LCFC_BOUND_MIN && $signed(upper_ff) <= LCFC_BOUND_MAX)
    else $error("upper bound outside allowed range");
  a_disabled_holds: assert property (!enable_ff && !tally_clear |=> tally == $past(tally))
    else $error("disabled check changed the tally");
  a_conflict_refused: assert property (conflict_ev |=> !enable_ff ##1 err_ff == LCFC_ERR_CONFLICT)
    else $error("enable accepted under conflicting speed");
  a_flag_tracks_tally: assert property (fail_flag_o == (tally != '0))
    else $error("failure flag disagrees with tally");
  a_once_first_clear: assert property (meas_start_i && policy_ff == LCFC_POL_ONCE && once_pend_ff
    |=> tally == '0)
    else $error("first start under once policy did not zero tally");
  a_once_arm: assert property (ctrl_wr && wr_policy == LCFC_POL_ONCE |=> once_pend_ff)
    else $error("once policy not armed on selection");
  a_clear_beats_inc: assert property (imm_clear && fail_ev |=> tally == '0 && !fail_flag_o)
    else $error("increment survived a same-cycle clear");
  a_wrap_event: assert property (fail_ev && !tally_clear && (&tally) |=> tally_wrap)
    else $error("wrap event missing");
  a_linear_pass: assert property (result_valid_i && linear_ff && result_i >= lower_ff
    && result_i <= upper_ff && !tally_clear |=> tally == $past(tally))
    else $error("linear result within bounds advanced the tally");
  a_default_lower: assert property (wr_i && addr_i == LCFC_OFS_BCMD && bcmd_code == LCFC_BCMD_DEF
    && !wdata_i[LCFC_BCMD_SEL_BIT] |=> lower_ff == LCFC_LOWER_DEF)
    else $error("default shortcut did not load the lower bound");
  a_default_upper: assert property (wr_i && addr_i == LCFC_OFS_BCMD && bcmd_code == LCFC_BCMD_DEF
    && wdata_i[LCFC_BCMD_SEL_BIT] |=> upper_ff == LCFC_UPPER_DEF)
    else $error("default shortcut did not load the upper bound");

  // read port and interrupt checks
  a_enable_readback: assert property (rd_i && addr_i == LCFC_OFS_CTRL
    |=> rdata_o[LCFC_CTRL_EN_BIT] == $past(enable_ff))
    else $error("enable read back wrong");
  a_tally_readback: assert property (rd_i && addr_i == LCFC_OFS_TALLY
    |=> rdata_o[TALLY_W-1:0] == $past(tally) && rdata_o[LCFC_FAIL_BIT] == $past(fail_flag_o))
    else $error("tally read back wrong");
  a_rdata_idle: assert property (!rd_i |=> rdata_o == '0)
    else $error("read data outside its read cycle");
  a_stat_sticky: assert property (events != '0 |=> (irq_stat_ff & $past(events)) == $past(events))
    else $error("event lost in interrupt status");
  a_irq_level: assert property (1'b1 |=> irq_o == (($past(irq_stat_ff) & $past(irq_en_ff)) != '0))
    else $error("interrupt line disagrees with status and enable");

  c_fail_counted: cover property (fail_ev ##1 fail_flag_o);
  c_tally_wrap: cover property (tally_wrap);
  c_conflict: cover property (conflict_ev);
  c_once_clear: cover property (meas_start_i && once_pend_ff && policy_ff == LCFC_POL_ONCE);
  c_equal_bound: cover property (enable_ff && result_valid_i && result_i == lower_ff);
endmodule
`default_nettype wire

// >>> tb/lcfc_acq_model.sv
// acquisition stage model feeding measurement starts and results
`timescale 1ns/1ps
`default_nettype none
module lcfc_acq_model (
  input wire logic clock_i,
  output logic meas_start_o,
  output logic result_valid_o,
  output logic [31:0] result_o
);
  int lat = 0;
  initial
  begin
    meas_start_o = 1'b0;
    result_valid_o = 1'b0;
    result_o = 32'hA5A5A5A5;
  end
  task automatic start();
    @(posedge clock_i);
    meas_start_o <= 1'b1;
    @(posedge clock_i);
    meas_start_o <= 1'b0;
  endtask
  // n back-to-back results; idle bus shows the inverse so stale data never matches
  task automatic measure(input logic [31:0] v, input int n);
    repeat (lat) @(posedge clock_i);
    @(posedge clock_i);
    result_valid_o <= 1'b1;
    result_o <= v;
    repeat (n) @(posedge clock_i);
    result_valid_o <= 1'b0;
    result_o <= ~v;
  endtask
endmodule
`default_nettype wire

// >>> tb/testbench.sv
// self-checking bench for the limit check failure counter
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import lcfc_pkg::*;
  logic clock_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic fast_i = 1'b0;
  logic spd_i = 1'b0;
  logic [31:0] rdata_o;
  logic fail_flag_o;
  logic irq_o;
  logic meas_start;
  logic res_valid;
  logic [31:0] result;
  logic [31:0] rv;
  int n_errors = 0;
  int n_compared = 0;
  localparam logic [31:0] HI = 32'h00002329;

  always #4 clock_i = ~clock_i;

  lcfc_top dut (.clock_i(clock_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .meas_start_i(meas_start),
    .result_valid_i(res_valid), .result_i(result), .measurement_rate_fast_i(fast_i),
    .speed_400_i(spd_i), .fail_flag_o(fail_flag_o), .irq_o(irq_o));
  lcfc_acq_model acq (.clock_i(clock_i), .meas_start_o(meas_start), .result_valid_o(res_valid),
    .result_o(result));

  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 rv = rdata_o;
    chk(what, rv, exp);
  endtask
  function automatic logic [31:0] tv(input int n);
    return {15'h0, n != 0, n[15:0]};
  endfunction

  task automatic t_reset();
    rchk("ctrl", LCFC_OFS_CTRL, 32'h00000002);
    rchk("lower", LCFC_OFS_LOWER, 32'hFFFFDCD8);
    rchk("upper", LCFC_OFS_UPPER, 32'h00002328);
    rchk("tally", LCFC_OFS_TALLY, 32'h0);
    rchk("unmapped", 8'h30, 32'h0);
    chk("flag", {31'h0, fail_flag_o}, 32'h0);
  endtask
  task automatic t_bounds();
    logic [31:0] v [4] = '{32'hFFFFDCD8, 32'h00002328, 32'hFFFFDCD7, HI};
    int e [4] = '{0, 0, 1, 2};
    wr(LCFC_OFS_CTRL, 32'h1);
    rchk("enable", LCFC_OFS_CTRL, 32'h1);
    for (int i = 0; i < 4; i++)
    begin
      acq.measure(v[i], 1);
      rchk("tally", LCFC_OFS_TALLY, tv(e[i]));
    end
    chk("flag", {31'h0, fail_flag_o}, 32'h1);
  endtask
  task automatic t_policy();
    wr(LCFC_OFS_CTRL, 32'h0);
    acq.measure(HI, 1);
    rchk("disabled", LCFC_OFS_TALLY, tv(2));
    wr(LCFC_OFS_CTRL, 32'h3);
    rchk("every sel", LCFC_OFS_TALLY, tv(0));
    acq.measure(HI, 1);
    acq.start();
    rchk("every start", LCFC_OFS_TALLY, tv(0));
    wr(LCFC_OFS_CTRL, 32'h5);
    acq.lat = 4;
    acq.measure(HI, 1);
    acq.lat = 0;
    rchk("once arm", LCFC_OFS_TALLY, tv(1));
    acq.start();
    rchk("once first", LCFC_OFS_TALLY, tv(0));
    acq.measure(HI, 1);
    acq.start();
    rchk("once later", LCFC_OFS_TALLY, tv(1));
    fork
      wr(LCFC_OFS_CLEAR, 32'h1);
      acq.measure(HI, 1);
    join
    rchk("clear wins", LCFC_OFS_TALLY, tv(0));
    acq.measure(HI, 1);
    wr(LCFC_OFS_CLEAR, 32'h1);
    rchk("clear", LCFC_OFS_TALLY, tv(0));
  endtask
  task automatic t_bcmd();
    logic [2:0] c [6] = '{3'h4, 3'h7, 3'h6, 3'h5, 3'h2, 3'h3};
    logic [31:0] e [6] = '{32'hFFFFC568, 32'h000059D8, 32'h000059D8, 32'hFFFFC568, 32'hFFFFDCD8, 32'h00002328};
    for (int i = 0; i < 6; i++)
    begin
      wr(LCFC_OFS_BCMD, {29'h0, c[i]});
      rchk("bcmd", c[i][0] ? LCFC_OFS_UPPER : LCFC_OFS_LOWER, e[i]);
    end
    rchk("bmin", LCFC_OFS_BMIN, 32'hFFFFC568);
    rchk("bmax", LCFC_OFS_BMAX, 32'h000059D8);
    wr(LCFC_OFS_LOWER, 32'hFFFFB1E0);
    rchk("clamp lo", LCFC_OFS_LOWER, 32'hFFFFC568);
    wr(LCFC_OFS_UPPER, 32'h00007530);
    rchk("clamp hi", LCFC_OFS_UPPER, 32'h000059D8);
  endtask
  // unsigned pass in linear unit, signed fail in log unit
  task automatic t_linear();
    wr(LCFC_OFS_CTRL, 32'h9);
    wr(LCFC_OFS_LOWER, 32'h5);
    wr(LCFC_OFS_UPPER, 32'h90000000);
    acq.measure(32'h80000000, 1);
    rchk("linear", LCFC_OFS_TALLY, tv(0));
    wr(LCFC_OFS_CTRL, 32'h1);
    acq.measure(32'h80000000, 1);
    rchk("log", LCFC_OFS_TALLY, tv(1));
    wr(LCFC_OFS_BCMD, 32'h2);
    wr(LCFC_OFS_BCMD, 32'h7);
    wr(LCFC_OFS_BCMD, 32'h1);
    rchk("bcmd idle", LCFC_OFS_UPPER, 32'h000059D8);
    wr(LCFC_OFS_BCMD, 32'h3);
    rchk("bcmd def", LCFC_OFS_UPPER, 32'h00002328);
  endtask
  task automatic t_conflict();
    for (int i = 0; i < 2; i++)
    begin
      wr(LCFC_OFS_CTRL, 32'h0);
      fast_i <= (i == 0);
      spd_i <= (i == 1);
      wr(LCFC_OFS_IRQ_CLR, 32'h7);
      wr(LCFC_OFS_CTRL, 32'h1);
      rchk("refused", LCFC_OFS_CTRL, 32'h0);
      rchk("err", LCFC_OFS_ERR, 32'hFFFFFF23);
      rchk("conflict", LCFC_OFS_IRQ_STAT, 32'h2);
    end
    fast_i <= 1'b0;
    spd_i <= 1'b0;
    wr(LCFC_OFS_CTRL, 32'h1);
    rchk("accepted", LCFC_OFS_CTRL, 32'h1);
  endtask
  task automatic t_irq();
    wr(LCFC_OFS_IRQ_CLR, 32'h7);
    wr(LCFC_OFS_IRQ_EN, 32'h1);
    acq.measure(HI, 1);
    @(posedge clock_i);
    #1 chk("irq set", {31'h0, irq_o}, 32'h1);
    wr(LCFC_OFS_IRQ_CLR, 32'h1);
    @(posedge clock_i);
    #1 chk("irq clr", {31'h0, irq_o}, 32'h0);
    wr(LCFC_OFS_IRQ_EN, 32'h0);
    acq.measure(HI, 1);
    repeat (2) @(posedge clock_i);
    #1 chk("irq mask", {31'h0, irq_o}, 32'h0);
    rchk("stat", LCFC_OFS_IRQ_STAT, 32'h1);
  endtask
  task automatic t_wrap();
    wr(LCFC_OFS_CLEAR, 32'h1);
    wr(LCFC_OFS_IRQ_CLR, 32'h7);
    acq.measure(HI, 65535);
    rchk("full", LCFC_OFS_TALLY, 32'h0001FFFF);
    acq.measure(HI, 1);
    rchk("wrap", LCFC_OFS_TALLY, 32'h0);
    chk("flag", {31'h0, fail_flag_o}, 32'h0);
    rchk("wrap stat", LCFC_OFS_IRQ_STAT, 32'h5);
  endtask

  task automatic close_out();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (3) @(posedge clock_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    t_reset();
    t_bounds();
    t_policy();
    t_bcmd();
    t_linear();
    t_conflict();
    t_irq();
    t_wrap();
    close_out();
  end
  // whole run is about 66k cycles
  initial
  begin
    #(8 * 90000);
    n_errors++;
    close_out();
  end
endmodule
`default_nettype wire
